//--- fec_top.sv
// Purpose: frame timing controller stepping idle, exposure, sampling, readout
// Assumes: request pins asynchronous; register port on core_clk
// Notes:   exposure runs as a flag beside the phase machine so it can overlap readout
//
// Overview of operation
// - three-bit mode register, four control modes
// - full external: exposure request starts exposure
// - full external: frame request starts sampling, readout
// - exposure spans request edge to frame edge
// - sampling and readout lengths from registers
// - new exposure accepted during readout
// - frame request in sampling restarts, marks corrupt
// - exposure request during exposure restarts exposure
// - frame request aborts readout, restarts sampling
// - programmed external: timer ends exposure
// - programmed external ignores frame requests
// - programmed external: request in sampling corrupts
// - programmed external: expiry in sampling restarts, corrupt
// - programmed external: request in exposure restarts
// - programmed external: expiry aborts readout, resamples
// - triggered internal: request from idle starts exposure
// - triggered internal counts frames against register
// - last readout completes, then idle
// - next exposure ends one frame time later
// - streaming: one request starts endless frames
// - streaming ignores all later requests
// - early request extends sequence, capped 255
`timescale 1ns/1ps
`default_nettype none
module fec_top (
  input  wire logic                    core_clk,
  input  wire logic                    reset,
  input  wire logic                    ce,
  input  wire logic                    exposure_request_in,
  input  wire logic                    frame_request_in,
  input  wire logic [fec_pkg::AW-1:0]  reg_addr,
  input  wire logic [fec_pkg::DW-1:0]  reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [fec_pkg::DW-1:0]  reg_rdata,
  output logic      [1:0]              state_o,
  output logic                         exposing_o,
  output logic                         frame_corrupt_o,
  output logic                         readout_abort_o,
  output logic                         frame_done_o
);

  // ********************************************************
  // request edges
  // ********************************************************
  logic [1:0] req_rise;
  logic       exp_rise;
  logic       frm_rise;

  fec_req_sync #(.N(2)) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .ce       (ce),
    .din      ({frame_request_in, exposure_request_in}),
    .rise     (req_rise)
  );

  assign exp_rise = req_rise[0];
  assign frm_rise = req_rise[1];

  // ********************************************************
  // registers
  // ********************************************************
  logic [2:0]             mode_r;
  logic [fec_pkg::TW-1:0] exp_time_r;
  logic [fec_pkg::TW-1:0] frame_time_r;
  logic [fec_pkg::TW-1:0] global_sample_state_len_r;
  logic [fec_pkg::TW-1:0] ro_len_r;
  logic [fec_pkg::CW-1:0] frame_cnt_r;

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      mode_r       <= fec_pkg::MODE_RST;
      exp_time_r   <= fec_pkg::EXP_TIME_RST;
      frame_time_r <= fec_pkg::FRAME_TIME_RST;
      global_sample_state_len_r   <= fec_pkg::GLOBAL_SAMPLE_STATE_LEN_RST;
      ro_len_r     <= fec_pkg::RO_LEN_RST;
      frame_cnt_r  <= fec_pkg::FRAME_CNT_RST;
    end
    else if (ce && reg_wr)
    begin
      case (reg_addr)
        fec_pkg::ADDR_MODE:       mode_r       <= reg_wdata[2:0];
        fec_pkg::ADDR_EXP_TIME:   exp_time_r   <= reg_wdata;
        fec_pkg::ADDR_FRAME_TIME: frame_time_r <= reg_wdata;
        fec_pkg::ADDR_GLOBAL_SAMPLE_STATE_LEN:   global_sample_state_len_r   <= reg_wdata;
        fec_pkg::ADDR_RO_LEN:     ro_len_r     <= reg_wdata;
        fec_pkg::ADDR_FRAME_CNT:  frame_cnt_r  <= reg_wdata[fec_pkg::CW-1:0];
        default:                  ;
      endcase
    end
  end

  // ********************************************************
  // mode decode and phase timers
  // ********************************************************
  logic is_fe;
  logic is_pe;
  logic is_ti;
  logic is_st;

  // codes 4..7 match no mode, so every request is ignored there
  assign is_fe = (mode_r == fec_pkg::MODE_FULL_EXT);
  assign is_pe = (mode_r == fec_pkg::MODE_PROG_EXT);
  assign is_ti = (mode_r == fec_pkg::MODE_TRIG_INT);
  assign is_st = (mode_r == fec_pkg::MODE_STREAM);

  fec_tmr_if #(.W(fec_pkg::TW)) global_sample_state_t ();
  fec_tmr_if #(.W(fec_pkg::TW)) ro_t ();
  fec_tmr_if #(.W(fec_pkg::TW)) exp_t ();
  fec_tmr_if #(.W(fec_pkg::TW)) frm_t ();

  fec_timer #(.W(fec_pkg::TW)) u_global_sample_state_tmr (.core_clk(core_clk), .reset(reset), .ce(ce), .t(global_sample_state_t.tmr));
  fec_timer #(.W(fec_pkg::TW)) u_ro_tmr   (.core_clk(core_clk), .reset(reset), .ce(ce), .t(ro_t.tmr));
  fec_timer #(.W(fec_pkg::TW)) u_exp_tmr  (.core_clk(core_clk), .reset(reset), .ce(ce), .t(exp_t.tmr));
  fec_timer #(.W(fec_pkg::TW)) u_frm_tmr  (.core_clk(core_clk), .reset(reset), .ce(ce), .t(frm_t.tmr));

  // ********************************************************
  // event decode
  // ********************************************************
  fec_pkg::fec_state_e    state_r;
  fec_pkg::fec_state_e    state_nxt;
  logic                   exposing_r;
  logic                   pending_r;
  logic                   streaming_r;
  logic                   global_sample_state_corrupt_r;
  logic [fec_pkg::CW-1:0] rem_r;
  logic [fec_pkg::CW-1:0] rem_nxt;
  logic [fec_pkg::CW-1:0] frames_read_r;

  logic in_ro;
  logic last_ro_started;
  logic ti_first;
  logic ti_new_seq;
  logic ti_extend;
  logic st_start;
  logic pend_set;
  logic pend_go;
  logic exp_load;
  logic exp_done;
  logic global_sample_state_go;
  logic global_sample_state_done;
  logic ro_done;
  logic [fec_pkg::CW:0] rem_sum;

  assign in_ro           = (state_r == fec_pkg::ST_READOUT) || (state_r == fec_pkg::ST_WAIT_EXP);
  assign last_ro_started = in_ro && (rem_r == '0);
  assign ti_first   = is_ti && exp_rise && (state_r == fec_pkg::ST_IDLE) && !exposing_r && !pending_r;
  assign ti_new_seq = is_ti && exp_rise && last_ro_started && !exposing_r && !pending_r;
  assign ti_extend  = is_ti && exp_rise && !ti_first && !ti_new_seq;
  assign st_start   = is_st && exp_rise && !streaming_r;

  // next frame of a sequence is scheduled while the current one reads out
  assign pend_set = in_ro && !exposing_r && !pending_r && (is_ti || is_st) &&
                    ((is_ti && rem_r != '0) || streaming_r);
  // start one cycle ahead so sampling begins exactly one frame time later; too short a frame starts now
  assign pend_go  = pending_r && (!frm_t.busy || frm_t.cnt <= exp_time_r ||
                                  (frm_t.cnt - exp_time_r) == fec_pkg::TW'(1));

  assign exp_load = ((is_fe || is_pe) && exp_rise) || ti_first || st_start || pend_go;
  assign exp_done = exposing_r && exp_t.expire && !is_fe && !exp_load;
  assign global_sample_state_go  = is_fe ? frm_rise : exp_done;
  assign global_sample_state_done = (state_r == fec_pkg::ST_GLOBAL_SAMPLE_STATE) && global_sample_state_t.expire && !global_sample_state_go;
  assign ro_done   = (state_r == fec_pkg::ST_READOUT) && ro_t.expire && !global_sample_state_go;

  assign global_sample_state_t.load  = ce && global_sample_state_go;
  assign global_sample_state_t.stop  = 1'b0;
  assign global_sample_state_t.value = global_sample_state_len_r;
  assign ro_t.load    = ce && global_sample_state_done;
  assign ro_t.stop    = 1'b0;
  assign ro_t.value   = ro_len_r;
  assign exp_t.load   = ce && exp_load;
  assign exp_t.stop   = ce && global_sample_state_go;
  assign exp_t.value  = exp_time_r;
  assign frm_t.load   = ce && global_sample_state_go && (is_ti || is_st);
  assign frm_t.stop   = 1'b0;
  assign frm_t.value  = frame_time_r;

  // ********************************************************
  // phase machine
  // ********************************************************
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      fec_pkg::ST_IDLE:
        if (global_sample_state_go)
          state_nxt = fec_pkg::ST_GLOBAL_SAMPLE_STATE;
      fec_pkg::ST_GLOBAL_SAMPLE_STATE:
        if (global_sample_state_go)
          state_nxt = fec_pkg::ST_GLOBAL_SAMPLE_STATE;
        else if (global_sample_state_t.expire)
          state_nxt = fec_pkg::ST_READOUT;
      fec_pkg::ST_READOUT:
        if (global_sample_state_go)
          state_nxt = fec_pkg::ST_GLOBAL_SAMPLE_STATE;
        else if (ro_t.expire)
          state_nxt = (exposing_r || pending_r || pend_set || exp_load) ?
                      fec_pkg::ST_WAIT_EXP : fec_pkg::ST_IDLE;
      fec_pkg::ST_WAIT_EXP:
        if (global_sample_state_go)
          state_nxt = fec_pkg::ST_GLOBAL_SAMPLE_STATE;
        else if (!exposing_r && !pending_r && !exp_load)
          state_nxt = fec_pkg::ST_IDLE;
      default:
        state_nxt = fec_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      state_r <= fec_pkg::ST_IDLE;
    else if (ce)
      state_r <= state_nxt;
  end

  // ********************************************************
  // exposure and scheduling
  // ********************************************************
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      exposing_r <= 1'b0;
    else if (ce)
    begin
      if (exp_load)
        exposing_r <= 1'b1;
      else if (global_sample_state_go)
        exposing_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      pending_r <= 1'b0;
    else if (ce)
    begin
      if (pend_go || !(is_ti || is_st))
        pending_r <= 1'b0;
      else if (pend_set || ti_new_seq)
        pending_r <= 1'b1;
    end
  end

  // only reset or leaving the mode ends a stream
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      streaming_r <= 1'b0;
    else if (ce)
    begin
      if (!is_st)
        streaming_r <= 1'b0;
      else if (st_start)
        streaming_r <= 1'b1;
    end
  end

  // ********************************************************
  // sequence length and frame counter
  // ********************************************************
  assign rem_sum = {1'b0, rem_r} + {1'b0, frame_cnt_r};

  always_comb
  begin
    rem_nxt = rem_r;
    if (ti_first || ti_new_seq)
      rem_nxt = frame_cnt_r;
    else if (ti_extend)
      rem_nxt = rem_sum[fec_pkg::CW] ? fec_pkg::FRAME_CNT_MAX : rem_sum[fec_pkg::CW-1:0];
    if (global_sample_state_go && is_ti && rem_nxt != '0)
      rem_nxt = rem_nxt - fec_pkg::CW'(1);
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      rem_r <= '0;
    else if (ce)
      rem_r <= rem_nxt;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      frames_read_r <= '0;
    else if (ce)
    begin
      if (ti_first || ti_new_seq || st_start)
        frames_read_r <= '0;
      else if (ro_done && frames_read_r != fec_pkg::FRAME_CNT_MAX)
        frames_read_r <= frames_read_r + fec_pkg::CW'(1);
    end
  end

  // ********************************************************
  // image integrity
  // ********************************************************
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      global_sample_state_corrupt_r <= 1'b0;
    else if (ce)
    begin
      if (global_sample_state_go)
        global_sample_state_corrupt_r <= (state_r == fec_pkg::ST_GLOBAL_SAMPLE_STATE) || (is_fe && !exposing_r);
      else if ((state_r == fec_pkg::ST_GLOBAL_SAMPLE_STATE) && exp_rise && (is_fe || is_pe))
        global_sample_state_corrupt_r <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      frame_corrupt_o <= 1'b0;
    else if (ce && global_sample_state_done)
      frame_corrupt_o <= global_sample_state_corrupt_r || (exp_rise && (is_fe || is_pe));
  end

  // ********************************************************
  // outputs and read port
  // ********************************************************
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      readout_abort_o <= 1'b0;
      frame_done_o    <= 1'b0;
    end
    else if (ce)
    begin
      readout_abort_o <= global_sample_state_go && (state_r == fec_pkg::ST_READOUT);
      frame_done_o    <= ro_done;
    end
  end

  assign state_o    = state_r;
  assign exposing_o = exposing_r;

  logic [fec_pkg::DW-1:0] status_w;

  always_comb
  begin
    status_w = '0;
    status_w[fec_pkg::STAT_STATE_LSB +: 2]               = state_r;
    status_w[fec_pkg::STAT_EXPOSING]                      = exposing_r;
    status_w[fec_pkg::STAT_PENDING]                       = pending_r;
    status_w[fec_pkg::STAT_STREAM]                        = streaming_r;
    status_w[fec_pkg::STAT_CORRUPT]                       = frame_corrupt_o;
    status_w[fec_pkg::STAT_FRAMES_LSB +: fec_pkg::CW]     = frames_read_r;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      reg_rdata <= '0;
    else if (ce)
    begin
      reg_rdata <= '0;
      if (reg_rd)
      begin
        case (reg_addr)
          fec_pkg::ADDR_MODE:       reg_rdata <= {13'h0000, mode_r};
          fec_pkg::ADDR_EXP_TIME:   reg_rdata <= exp_time_r;
          fec_pkg::ADDR_FRAME_TIME: reg_rdata <= frame_time_r;
          fec_pkg::ADDR_FRAME_CNT:  reg_rdata <= {8'h00, frame_cnt_r};
          fec_pkg::ADDR_GLOBAL_SAMPLE_STATE_LEN:   reg_rdata <= global_sample_state_len_r;
          fec_pkg::ADDR_RO_LEN:     reg_rdata <= ro_len_r;
          fec_pkg::ADDR_STATUS:     reg_rdata <= status_w;
          default:                  reg_rdata <= '0;
        endcase
      end
    end
  end

  // ********************************************************
  // assertions
  // ********************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_mode_write;
    (ce && reg_wr && reg_addr == fec_pkg::ADDR_MODE) |=> (mode_r == $past(reg_wdata[2:0]));
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode register not written");

  property p_fe_exp_start;
    (ce && is_fe && exp_rise && !frm_rise) |=> exposing_o;
  endproperty
  a_fe_exp_start: assert property (p_fe_exp_start) else $error("exposure not started");

  sequence s_frame_edge;
    ce && is_fe && frm_rise && !exp_rise;
  endsequence
  property p_fe_frame_global_sample_state;
    s_frame_edge |=> (state_o == fec_pkg::ST_GLOBAL_SAMPLE_STATE) && !exposing_o;
  endproperty
  a_fe_frame_global_sample_state: assert property (p_fe_frame_global_sample_state) else $error("frame edge did not start sampling");

  property p_global_sample_state_to_ro;
    (ce && global_sample_state_done) |=> (state_o == fec_pkg::ST_READOUT) && (ro_t.cnt == $past(ro_len_r) || $past(ro_len_r) == '0);
  endproperty
  a_global_sample_state_to_ro: assert property (p_global_sample_state_to_ro) else $error("sampling did not flow into readout");

  property p_pe_ignore_frame;
    (ce && is_pe && frm_rise && state_o == fec_pkg::ST_IDLE && !exposing_r) |=> (state_o == fec_pkg::ST_IDLE);
  endproperty
  a_pe_ignore_frame: assert property (p_pe_ignore_frame) else $error("frame edge not ignored");

  sequence s_ro_interrupt;
    ce && global_sample_state_go && state_r == fec_pkg::ST_READOUT;
  endsequence
  property p_ro_abort;
    s_ro_interrupt |=> readout_abort_o && (state_o == fec_pkg::ST_GLOBAL_SAMPLE_STATE) ##1 !readout_abort_o || !ce;
  endproperty
  a_ro_abort: assert property (p_ro_abort) else $error("readout not aborted");

  property p_global_sample_state_restart_corrupt;
    (ce && global_sample_state_go && state_r == fec_pkg::ST_GLOBAL_SAMPLE_STATE) |=> global_sample_state_corrupt_r && (state_o == fec_pkg::ST_GLOBAL_SAMPLE_STATE);
  endproperty
  a_global_sample_state_restart_corrupt: assert property (p_global_sample_state_restart_corrupt) else $error("sampling restart not corrupt");

  property p_pe_exp_restart;
    (ce && is_pe && exposing_r && exp_rise && exp_time_r != '0) |=> exposing_o && (exp_t.cnt == $past(exp_time_r));
  endproperty
  a_pe_exp_restart: assert property (p_pe_exp_restart) else $error("exposure not restarted");

  property p_ti_last_idle;
    (ce && is_ti && ro_done && rem_r == '0 && !exposing_r && !pending_r && !exp_rise) |=> (state_o == fec_pkg::ST_IDLE);
  endproperty
  a_ti_last_idle: assert property (p_ti_last_idle) else $error("sequence did not end in idle");

  property p_stream_ignore;
    (ce && is_st && streaming_r && exp_rise && !pend_go && !global_sample_state_go) |=> $stable(exposing_o);
  endproperty
  a_stream_ignore: assert property (p_stream_ignore) else $error("stream reacted to request");

endmodule : fec_top
`default_nettype wire

//--- fec_pkg.sv
// Purpose: constants and types shared by the frame exposure control block
// Assumes: registers reached over a plain address/strobe port, 16-bit data
// Notes:   all times are in core_clk cycles
package fec_pkg;

  // ********************************************************
  // widths
  // ********************************************************
  localparam int DW = 16;
  localparam int AW = 8;
  localparam int TW = 16;
  localparam int CW = 8;

  // ********************************************************
  // register map
  // ********************************************************
  localparam logic [AW-1:0] ADDR_MODE       = 8'h09;
  localparam logic [AW-1:0] ADDR_EXP_TIME   = 8'h10;
  localparam logic [AW-1:0] ADDR_FRAME_TIME = 8'h11;
  localparam logic [AW-1:0] ADDR_FRAME_CNT  = 8'h12;
  localparam logic [AW-1:0] ADDR_GLOBAL_SAMPLE_STATE_LEN   = 8'h13;
  localparam logic [AW-1:0] ADDR_RO_LEN     = 8'h14;
  localparam logic [AW-1:0] ADDR_STATUS     = 8'h15;

  localparam logic [2:0]    MODE_RST        = 3'h0;
  localparam logic [TW-1:0] EXP_TIME_RST    = 16'h0100;
  localparam logic [TW-1:0] FRAME_TIME_RST  = 16'h1000;
  localparam logic [TW-1:0] GLOBAL_SAMPLE_STATE_LEN_RST    = 16'h0040;
  localparam logic [TW-1:0] RO_LEN_RST      = 16'h0800;
  localparam logic [CW-1:0] FRAME_CNT_RST   = 8'h01;
  localparam logic [CW-1:0] FRAME_CNT_MAX   = 8'hff;

  // status word field positions
  localparam int STAT_STATE_LSB   = 0;
  localparam int STAT_EXPOSING    = 2;
  localparam int STAT_PENDING     = 3;
  localparam int STAT_STREAM      = 4;
  localparam int STAT_CORRUPT     = 5;
  localparam int STAT_FRAMES_LSB  = 8;

  // ********************************************************
  // enumerations
  // ********************************************************
  typedef enum logic [2:0] {
    MODE_FULL_EXT = 3'h0,
    MODE_PROG_EXT = 3'h1,
    MODE_TRIG_INT = 3'h2,
    MODE_STREAM   = 3'h3
  } fec_mode_e;

  // gray along idle -> sample -> readout -> wait
  typedef enum logic [1:0] {
    ST_IDLE     = 2'h0,
    ST_GLOBAL_SAMPLE_STATE     = 2'h1,
    ST_READOUT  = 2'h3,
    ST_WAIT_EXP = 2'h2
  } fec_state_e;

endpackage : fec_pkg

//--- fec_tmr_if.sv
// Purpose: control and status bundle of one down-counting phase timer
// Assumes: one controller, one timer per instance
// Notes:   expire is high in the last counted cycle
`timescale 1ns/1ps
`default_nettype none
interface fec_tmr_if #(parameter int W = 16);
  logic         load;
  logic         stop;
  logic [W-1:0] value;
  logic [W-1:0] cnt;
  logic         busy;
  logic         expire;
  modport ctrl (output load, stop, value, input cnt, busy, expire);
  modport tmr  (input load, stop, value, output cnt, busy, expire);
endinterface : fec_tmr_if
`default_nettype wire

//--- fec_timer.sv
// Purpose: phase timer, loads a length and counts it down to zero
// Assumes: a zero length is run as one cycle
// Notes:   load wins over stop
`timescale 1ns/1ps
`default_nettype none
module fec_timer #(
  parameter int W = 16
) (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic ce,
  fec_tmr_if.tmr    t
);

  logic [W-1:0] cnt_r;

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      cnt_r <= '0;
    else if (ce)
    begin
      if (t.load)
        cnt_r <= (t.value == '0) ? W'(1) : t.value;
      else if (t.stop)
        cnt_r <= '0;
      else if (cnt_r != '0)
        cnt_r <= cnt_r - W'(1);
    end
  end

  assign t.cnt    = cnt_r;
  assign t.busy   = (cnt_r != '0);
  assign t.expire = (cnt_r == W'(1));

endmodule : fec_timer
`default_nettype wire

//--- fec_req_sync.sv
// Purpose: brings request pins into the core_clk domain and finds rising edges
// Assumes: pins are asynchronous to core_clk
// Notes:   pulses shorter than two clocks may be missed
`timescale 1ns/1ps
`default_nettype none
module fec_req_sync #(
  parameter int N = 2
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic         ce,
  input  wire logic [N-1:0] din,
  output logic      [N-1:0] rise
);

  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_bit
      logic meta_r;
      logic sync_r;
      logic prev_r;
      always_ff @(posedge core_clk or posedge reset)
      begin
        if (reset)
        begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
          prev_r <= 1'b0;
        end
        else if (ce)
        begin
          meta_r <= din[i];
          sync_r <= meta_r;
          prev_r <= sync_r;
        end
      end
      assign rise[i] = ce & sync_r & ~prev_r;
    end
  endgenerate

endmodule : fec_req_sync
`default_nettype wire

//--- fec_ctrl_model.sv
// Purpose: camera controller model driving the two request pins
// Assumes: each request is a pin pulse three clocks high
// Notes:   pins are driven push-pull, so they never float
`timescale 1ns/1ps
`default_nettype none
module fec_ctrl_model (
  input  wire logic core_clk,
  input  wire logic exp_go,
  input  wire logic frame_go,
  output logic      exposure_request_in,
  output logic      frame_request_in
);
  logic [1:0] exp_cnt_r = 2'h0;
  logic [1:0] frm_cnt_r = 2'h0;
  // three clocks high so the two-flop synchroniser cannot miss a pulse
  always_ff @(posedge core_clk)
  begin
    exp_cnt_r <= exp_go ? 2'h3 : (exp_cnt_r != 2'h0 ? exp_cnt_r - 2'h1 : 2'h0);
  end
  always_ff @(posedge core_clk)
  begin
    frm_cnt_r <= frame_go ? 2'h3 : (frm_cnt_r != 2'h0 ? frm_cnt_r - 2'h1 : 2'h0);
  end
  assign exposure_request_in = (exp_cnt_r != 2'h0);
  assign frame_request_in    = (frm_cnt_r != 2'h0);
endmodule : fec_ctrl_model
`default_nettype wire

//--- fec_top_tb.sv
// Purpose: self-checking bench for the frame exposure control block
// Assumes: phase lengths set to short cycle counts
// Notes:   request pins come from the controller model
`timescale 1ns/1ps
`default_nettype none
module fec_top_tb;
  logic        core_clk    = 1'b0;
  logic        reset       = 1'b1;
  logic        exp_go      = 1'b0;
  logic        frame_go    = 1'b0;
  logic        pin_exp;
  logic        pin_frm;
  logic [7:0]  reg_addr    = 8'h00;
  logic [15:0] reg_wdata   = 16'h0000;
  logic        reg_wr      = 1'b0;
  logic        reg_rd      = 1'b0;
  logic [15:0] reg_rdata;
  logic [1:0]  state_o;
  logic        exposing_o;
  logic        frame_corrupt_o;
  logic        frame_done_o;
  logic        readout_abort_o;
  int          p0;
  int          p1;
  logic [15:0] v;
  int          n;
  int          bad_count   = 0;
  int          comparisons = 0;
  always #4 core_clk = ~core_clk;
  fec_ctrl_model ctl (.core_clk(core_clk), .exp_go(exp_go), .frame_go(frame_go),
    .exposure_request_in(pin_exp), .frame_request_in(pin_frm));
  fec_top uut (.core_clk(core_clk), .reset(reset), .ce(1'b1), .exposure_request_in(pin_exp),
    .frame_request_in(pin_frm), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .state_o(state_o), .exposing_o(exposing_o),
    .frame_corrupt_o(frame_corrupt_o), .readout_abort_o(readout_abort_o), .frame_done_o(frame_done_o));
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      $display("Error %s expected %h seen %h", what, exp, seen);
      bad_count++;
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic pulse(input bit frm);
    @(posedge core_clk);
    if (frm)
      frame_go <= 1'b1;
    else
      exp_go <= 1'b1;
    @(posedge core_clk);
    exp_go   <= 1'b0;
    frame_go <= 1'b0;
  endtask : pulse
  // bounded wait; n returns the edges it took
  task automatic wst(input logic [1:0] s, input int lim);
    n = 0;
    while (state_o !== s && n < lim)
    begin
      @(posedge core_clk);
      #1 n++;
    end
    if (state_o !== s)
    begin
      $display("Error state wait expected %h seen %h", s, state_o);
      bad_count++;
      close_out();
    end
  endtask : wst
  initial
  begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    rd(8'h09);
    check("mode reset", v, 16'h0000);
    for (int m = 3; m >= 0; m--)
    begin
      wr(8'h09, 16'(m));
      rd(8'h09);
      check("mode", v, 16'(m));
    end
    rd(8'h30);
    check("unmapped", v, 16'h0000);
    wr(8'h13, 16'h0008);
    wr(8'h14, 16'h0014);
    wr(8'h10, 16'h0006);
    wr(8'h11, 16'h0028);
    wr(8'h12, 16'h0002);
    $display("registers done");
    pulse(1'b0);
    repeat (6) @(posedge core_clk);
    #1 check("exposing", 16'(exposing_o), 16'h0001);
    pulse(1'b1);
    wst(2'h1, 10);
    wst(2'h3, 20);
    check("sample len", 16'(n), 16'h0008);
    check("corrupt", 16'(frame_corrupt_o), 16'h0000);
    pulse(1'b0);
    pulse(1'b1);
    wst(2'h1, 12);
    check("abort", 16'(readout_abort_o), 16'h0001);
    wst(2'h3, 20);
    check("corrupt", 16'(frame_corrupt_o), 16'h0000);
    wst(2'h0, 30);
    check("readout len", 16'(n), 16'h0014);
    check("done", 16'(frame_done_o), 16'h0001);
    pulse(1'b1);
    wst(2'h3, 30);
    check("corrupt", 16'(frame_corrupt_o), 16'h0001);
    wst(2'h0, 30);
    pulse(1'b0);
    pulse(1'b1);
    wst(2'h1, 10);
    pulse(1'b1);
    wst(2'h3, 30);
    check("corrupt", 16'(frame_corrupt_o), 16'h0001);
    wst(2'h0, 30);
    $display("full external done");
    wr(8'h09, 16'h0001);
    pulse(1'b1);
    repeat (10) @(posedge core_clk);
    #1 check("state", 16'(state_o), 16'h0000);
    pulse(1'b0);
    repeat (3) @(posedge core_clk);
    pulse(1'b0);
    wst(2'h1, 20);
    check("restart", 16'(n), 16'h0009);
    check("state", 16'(state_o), 16'h0001);
    wst(2'h0, 40);
    $display("programmed external done");
    for (int m = 2; m <= 3; m++)
    begin
      wr(8'h09, 16'(m));
      pulse(1'b0);
      n = 0;
      p0 = 0;
      p1 = 0;
      for (int c = 0; c < 300; c++)
      begin
        @(posedge core_clk);
        #1 if (frame_done_o === 1'b1)
        begin
          n++;
          if (n == 1)
            p0 = c;
          if (n == 2)
            p1 = c;
        end
      end
      check("frame time", 16'(p1 - p0), 16'h0028);
      if (m == 2)
        check("frames", 16'(n), 16'h0002);
      else
        check("frames", 16'(n >= 5), 16'h0001);
      if (m == 3)
      begin
        pulse(1'b0);
        repeat (6) @(posedge core_clk);
        rd(8'h15);
        check("stream status", 16'(v[4]), 16'h0001);
      end
      $display("sequence mode done");
    end
    close_out();
  end
endmodule : fec_top_tb
`default_nettype wire
